//--- logic/processor_mode_status_defs.svh
`ifndef PROCESSOR_MODE_STATUS_DEFS_SVH
`define PROCESSOR_MODE_STATUS_DEFS_SVH
`define PMS_OFFSET 8'h00
`define FX_OFFSET 8'h04
`define PMS_RESET_LOW7 7'h00
`define VPP_MSB 15
`define VPP_LSB 7
`define VPP_RESET 9'h1FF
`define ROM_BIT 6
`define RAM_OVERLAY_BIT 5
`define ADDRESS_VISIBILITY_BIT 4
`define DMAP_BIT 3
`define CLOCK_OUTPUT_OFF_BIT 2
`define MULTIPLY_SATURATION_BIT 1
`define SST_BIT 0
`define FX_OVM_BIT 0
`define FX_FRACTIONAL_MODE_BIT 1
`define FX_SWRST_BIT 2
`define PAGE0_TOP 16'h007F
`define RAM_OVERLAY_TOP 16'h7FFF
`define DMAP_LO 17'h18000
`define DMAP_HI 17'h1FFFF
`define CLK_DIV_HALF 4'h2
`endif

//--- logic/processor_mode_status_pkg.sv
package processor_mode_status_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;
  typedef logic [8:0] vec_page_t;
endpackage

//--- logic/sat_unit.sv
`timescale 1ns/1ps
`include "processor_mode_status_defs.svh"
// ****************************************
// Saturating arithmetic helpers
// ****************************************
module sat_unit (
  input wire logic [31:0] product,
  input wire logic [39:0] acc,
  input wire logic [5:0] shift,
  input wire logic mul_sat_en,
  input wire logic store_sat_en,
  output logic [31:0] product_out,
  output logic [15:0] store_out
);
  logic [39:0] shifted;
  always_comb begin
    // Only the full negative square overflows a fractional multiply.
    product_out = product;
    if (mul_sat_en && product == 32'h80000000) begin
      product_out = 32'h7FFFFFFF;
    end
  end
  always_comb begin
    shifted = acc <<< shift;
    store_out = shifted[15:0];
    // Saturation follows the shift so shifted-out bits are judged too.
    if (store_sat_en) begin
      if (!shifted[39] && shifted[38:15] != 24'h000000) begin
        store_out = 16'h7FFF;
      end else if (shifted[39] && shifted[38:15] != 24'hFFFFFF) begin
        store_out = 16'h8000;
      end
    end
  end
endmodule

//--- logic/processor_mode_status_control.sv
`timescale 1ns/1ps
`include "processor_mode_status_defs.svh"
// Overview of operation
// - Bits 15 to 7 hold the 9-bit vector page pointer.
// - Hardware reset sets the pointer to all ones, reset vector at FF80h.
// - Software reset instruction leaves the pointer unchanged.
// - ROM mode bit 6 zero enables on-chip ROM, one disables it.
// - ROM mode bit loads from the mode pin at hardware reset only.
// - Software may freely set or clear the ROM mode bit afterwards.
// - Overlay bit 5 maps dual RAM into program space except page 0.
// - Visibility zero keeps the external address lines at the last external access address.
// - Visibility one drives the internal program address onto the pins.
// - Data map bit 3 maps dual RAM blocks four to seven into data space.
// - Clock output off bit 2 holds the clock output pin high.
// - Multiply saturation applies when overflow and fractional modes are set.
// - Store saturation clamps accumulator data after the shift.
// - Overlay RAM occupies data addresses 0080h to 7FFFh.
// - Data map RAM lives at program addresses 18000h to 1FFFFh.
module processor_mode_status_control
  import processor_mode_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic rom_mode_select,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [22:0] prog_addr,
  input wire logic prog_ext_access,
  input wire logic [6:0] vector_offset,
  input wire logic [15:0] data_addr,
  input wire logic [31:0] product,
  input wire logic [39:0] acc,
  input wire logic [5:0] store_shift,
  output logic [22:0] ext_addr,
  output logic clock_output_pin,
  output logic [15:0] vector_fetch_addr,
  output logic rom_enable,
  output logic prog_ram_hit,
  output logic data_ram_hit,
  output logic [31:0] product_out,
  output logic [15:0] store_out
);
  import processor_mode_status_pkg::*;
  // ****************************************
  // Mode register
  // ****************************************
  logic [15:0] pms_q;
  logic [2:0] fx_q;
  logic rst_seen_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  wr_state_t wr_q;
  rd_state_t rd_q;
  logic do_write;
  logic [15:0] wmask;
  logic [15:0] pms_wr;
  logic soft_reset;
  logic aw_is_mode;
  logic aw_is_aux;
  logic pms_sel;
  logic aux_sel;

  // The whole address is decoded so that no alias of a register answers.
  assign aw_is_mode = awaddr_q == {24'h000000, `PMS_OFFSET};
  assign aw_is_aux = awaddr_q == {24'h000000, `FX_OFFSET};
  assign do_write = (wr_q == WR_IDLE) && aw_have_q && w_have_q;
  assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign pms_wr = (pms_q & ~wmask) | (wdata_q[15:0] & wmask);
  assign pms_sel = do_write && aw_is_mode;
  // Only byte lane 0 carries the auxiliary bits.
  assign aux_sel = do_write && aw_is_aux && wstrb_q[0];
  assign soft_reset = aux_sel && wdata_q[`FX_SWRST_BIT];

  // ****************************************
  // Reset strap capture
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_seen_q <= 1'b0;
    end else if (clk_en) begin
      rst_seen_q <= 1'b1;
    end
  end

  // ****************************************
  // Mode register update
  // ****************************************
  logic [15:0] pms_d;
  always_comb begin
    pms_d = pms_q;
    if (!rst_seen_q) begin
      // The strap is caught on the first enabled edge after release. A bus write on
      // that same edge loses, so the pin level is taken exactly once per reset.
      pms_d[`ROM_BIT] = rom_mode_select;
    end else if (pms_sel) begin
      pms_d = pms_wr;
    end else if (soft_reset) begin
      // Soft reset clears the mode bits but keeps the pointer and ROM bit.
      pms_d[5:0] = 6'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pms_q <= {`VPP_RESET, `PMS_RESET_LOW7};
    end else if (clk_en) begin
      pms_q <= pms_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fx_q <= 3'h0;
    end else if (clk_en && aux_sel) begin
      fx_q <= {1'b0, wdata_q[1:0]};
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write response channel
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clk_en) begin
      case (wr_q)
        WR_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_is_mode || aw_is_aux) ? 2'b00 : 2'b10;
            wr_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_q <= WR_IDLE;
          end
        end
        default: wr_q <= WR_IDLE;
      endcase
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  always_comb begin
    rdata_d = 32'h00000000;
    rresp_d = 2'b00;
    if (s_axi_araddr == {24'h000000, `PMS_OFFSET}) begin
      rdata_d = {16'h0000, pms_q};
    end else if (s_axi_araddr == {24'h000000, `FX_OFFSET}) begin
      // The soft reset bit is a pulse and always reads back as zero.
      rdata_d = {29'h00000000, fx_q};
    end else begin
      rresp_d = 2'b10;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_q <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      case (rd_q)
        RD_IDLE: begin
          if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            rd_q <= RD_RESP;
            s_axi_rresp <= rresp_d;
            s_axi_rdata <= rdata_d;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_q <= RD_IDLE;
          end
        end
        default: rd_q <= RD_IDLE;
      endcase
    end
  end

  // ****************************************
  // Memory map decode
  // ****************************************
  logic ram_overlay_window;
  logic dmap_prog_window;
  logic data_low_window;
  logic data_high_window;
  logic prog_hit_d;
  logic data_hit_d;
  // Page 0 of data space never overlays, so the window starts just above it.
  assign ram_overlay_window = prog_addr[22:16] == 7'h00 && prog_addr[15:0] > `PAGE0_TOP &&
                       prog_addr[15:0] <= `RAM_OVERLAY_TOP;
  assign dmap_prog_window = prog_addr >= {6'h00, `DMAP_LO} &&
                            prog_addr <= {6'h00, `DMAP_HI};
  assign data_low_window = data_addr > `PAGE0_TOP && data_addr <= `RAM_OVERLAY_TOP;
  assign data_high_window = data_addr > `RAM_OVERLAY_TOP;
  assign prog_hit_d = (pms_q[`RAM_OVERLAY_BIT] && ram_overlay_window) || dmap_prog_window;
  assign data_hit_d = data_low_window || (pms_q[`DMAP_BIT] && data_high_window);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vector_fetch_addr <= 16'hFF80;
      rom_enable <= 1'b0;
      prog_ram_hit <= 1'b0;
      data_ram_hit <= 1'b0;
    end else if (clk_en) begin
      vector_fetch_addr <= {pms_q[`VPP_MSB:`VPP_LSB], vector_offset};
      rom_enable <= !pms_q[`ROM_BIT];
      prog_ram_hit <= prog_hit_d;
      data_ram_hit <= data_hit_d;
    end
  end

  // ****************************************
  // External address pins
  // ****************************************
  logic [22:0] ext_addr_d;
  always_comb begin
    // Without visibility the pins only move for real external accesses, so a
    // trace probe sees a quiet bus while code runs from on-chip memory.
    ext_addr_d = ext_addr;
    if (pms_q[`ADDRESS_VISIBILITY_BIT] || prog_ext_access) begin
      ext_addr_d = prog_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_addr <= 23'h000000;
    end else if (clk_en) begin
      ext_addr <= ext_addr_d;
    end
  end

  // ****************************************
  // Clock output pin
  // ****************************************
  // The divider keeps counting while the pin is held, so turning it back on
  // resumes at the running phase instead of restarting it.
  logic [3:0] div_q;
  logic clk_ph_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      clk_ph_q <= 1'b0;
      clock_output_pin <= 1'b1;
    end else if (clk_en) begin
      if (div_q == `CLK_DIV_HALF - 4'h1) begin
        div_q <= 4'h0;
        clk_ph_q <= !clk_ph_q;
      end else begin
        div_q <= div_q + 4'h1;
      end
      clock_output_pin <= pms_q[`CLOCK_OUTPUT_OFF_BIT] ? 1'b1 : clk_ph_q;
    end
  end

  // ****************************************
  // Saturation
  // ****************************************
  logic [31:0] prod_c;
  logic [15:0] store_c;
  sat_unit u_sat (
    .product(product),
    .acc(acc),
    .shift(store_shift),
    .mul_sat_en(pms_q[`MULTIPLY_SATURATION_BIT] && fx_q[`FX_OVM_BIT] && fx_q[`FX_FRACTIONAL_MODE_BIT]),
    .store_sat_en(pms_q[`SST_BIT]),
    .product_out(prod_c),
    .store_out(store_c)
  );
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      product_out <= 32'h00000000;
      store_out <= 16'h0000;
    end else if (clk_en) begin
      product_out <= prod_c;
      store_out <= store_c;
    end
  end
endmodule

//--- verification/processor_mode_status_monitor.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module processor_mode_status_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic rom_mode_select,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [22:0] prog_addr,
  input wire logic [6:0] vector_offset,
  input wire logic [15:0] data_addr,
  input wire logic [22:0] ext_addr,
  input wire logic [15:0] vector_fetch_addr,
  input wire logic rom_enable,
  input wire logic prog_ram_hit,
  input wire logic data_ram_hit
);
  logic live_q;
  // High when the previous edge ran, so one-cycle decodes can be traced to it.
  always_ff @(posedge ref_clk) begin
    live_q <= rst_n && clk_en;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_vec_offset: assert property (live_q |->
    vector_fetch_addr[6:0] == $past(vector_offset)) else $error("vector offset wrong");
  chk_ptr_reset: assert property ($rose(rst_n) |->
    vector_fetch_addr[15:7] == 9'h1FF) else $error("pointer not all ones");
  chk_strap_load: assert property ($rose(rst_n) && clk_en |->
    ##[1:2] rom_enable == !rom_mode_select) else $error("strap not loaded");
  chk_ext_source: assert property (live_q && $changed(ext_addr) |->
    ext_addr == $past(prog_addr)) else $error("pins moved to a foreign address");
  chk_high_ram: assert property (live_q && $past(prog_addr) inside {[23'h18000:23'h1FFFF]} |->
    prog_ram_hit) else $error("upper ram missed");
  chk_page_zero: assert property (live_q && $past(prog_addr) <= 23'h7F |->
    !prog_ram_hit) else $error("page zero mapped");
  chk_data_low: assert property (live_q && $past(data_addr) inside {[16'h80:16'h7FFF]} |->
    data_ram_hit) else $error("data ram missed");
  chk_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read answer late");
  chk_bad_addr: assert property (s_axi_arready && s_axi_araddr[31:3] != 29'h0 |->
    s_axi_rresp == 2'b10) else $error("unmapped read not refused");
endmodule
bind processor_mode_status_control processor_mode_status_monitor u_processor_mode_status_monitor (
  .ref_clk, .rst_n, .clk_en, .rom_mode_select, .s_axi_araddr, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rresp, .prog_addr, .vector_offset, .data_addr, .ext_addr, .vector_fetch_addr,
  .rom_enable, .prog_ram_hit, .data_ram_hit);

//--- verification/test_processor_mode_status_control.sv
`timescale 1ns/1ps
`include "processor_mode_status_defs.svh"
module test_processor_mode_status_control;
  logic ref_clk, rst_n, clk_en, rom_mode_select, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, prog_ext_access, clock_output_pin, rom_enable, prog_ram_hit, data_ram_hit;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, product, product_out;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [22:0] prog_addr, ext_addr;
  logic [6:0] vector_offset;
  logic [15:0] data_addr, vector_fetch_addr, store_out;
  logic [39:0] acc;
  logic [5:0] store_shift;
  int bad_count, n_compared;
  // Rows: mode word, then rom enable, program hit, data hit, clock pin held high.
  localparam logic [19:0] ROWS [4] = '{20'h00008, 20'h00645, 20'h1E08A, 20'h7F571};
  processor_mode_status_control u_processor_mode_status_control (.ref_clk, .rst_n, .clk_en,
    .rom_mode_select, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .prog_addr, .prog_ext_access, .vector_offset, .data_addr, .product, .acc,
    .store_shift, .ext_addr, .clock_output_pin, .vector_fetch_addr, .rom_enable,
    .prog_ram_hit, .data_ram_hit, .product_out, .store_out);
  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] m;
    logic [22:0] prev;
    logic hi;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {clk_en, rom_mode_select, prog_ext_access, s_axi_wstrb} = 7'h4F;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, product, acc, store_shift} = '0;
    {prog_addr, vector_offset} = '0;
    data_addr = 16'h0200;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    data_addr <= 16'h9000;
    for (int i = 0; i < 4; i++) begin
      m = ROWS[i][19:4];
      prev = ext_addr;
      prog_addr <= 23'h100 + 23'(i);
      vector_offset <= 7'h11 + 7'(i);
      wr(`PMS_OFFSET, {16'h0, m});
      repeat (3) @(posedge ref_clk);
      rd(`PMS_OFFSET, d, r);
      check("mode", d, {16'h0, m});
      check("rom", rom_enable, ROWS[i][3]);
      check("phit", prog_ram_hit, ROWS[i][2]);
      check("dhit", data_ram_hit, ROWS[i][1]);
      check("ext", ext_addr, m[4] ? 23'h100 + 23'(i) : prev);
      check("vec", vector_fetch_addr, {m[15:7], 7'h11 + 7'(i)});
      hi = 1;
      repeat (4) begin
        @(posedge ref_clk);
        if (clock_output_pin !== 1'b1) hi = 0;
      end
      check("clk", hi, ROWS[i][0]);
      $display("row %0d done", i);
    end
    prog_addr <= 23'h18000;
    product <= 32'h80000000;
    acc <= 40'h4000;
    store_shift <= 6'h1;
    wr(`FX_OFFSET, 32'h3);
    wr(`PMS_OFFSET, 32'h3);
    repeat (3) @(posedge ref_clk);
    check("phi", prog_ram_hit, 1'b1);
    check("prod", product_out, 32'h7FFFFFFF);
    // A shift of one turns 4000h into 8000h, so only clamping after it gives 7FFFh.
    check("store", store_out, 16'h7FFF);
    wr(`FX_OFFSET, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("prod", product_out, 32'h80000000);
    rd(32'h8, d, r);
    check("resp", r, 2'b10);
    check("zero", d, 32'h0);
    // Visibility is off here, so only a real external access may move the pins.
    prog_addr <= 23'h2345;
    prog_ext_access <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("extacc", ext_addr, 23'h2345);
    prog_ext_access <= 1'b0;
    prog_addr <= 23'h0777;
    repeat (3) @(posedge ref_clk);
    check("exthold", ext_addr, 23'h2345);
    wr(`PMS_OFFSET, 32'h1E7F);
    wr(`FX_OFFSET, 32'h4);
    rd(`PMS_OFFSET, d, r);
    check("swrst", d, 32'h1E40);
    $display("saturation and refusal done");
    rom_mode_select <= 1'b0;
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rom_mode_select <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`PMS_OFFSET, d, r);
    check("hwrst", d, 32'hFF80);
    check("rom", rom_enable, 1'b1);
    $display("reset done");
    report_and_stop();
  end
endmodule
